//--- hw/pin_sync3.sv
// Purpose: three-stage synchroniser with agreement filter for pins
// Assumes: inputs are asynchronous to clk_in
// Notes:   level changes only when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] idle_level_in,
  output logic      [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [3:0]       fill;
  } sync_s;

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st       = st;
    next_st.s1    = pin_in;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.level = (st.s2 & st.s3) | (st.level & (st.s2 ^ st.s3));
    next_st.fill  = {st.fill[2:0], 1'b1};
  end

  // idle level shown until the stages fill
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.fill[3] ? st.level : idle_level_in;
endmodule // pin_sync3

//--- hw/usart_char_engine.sv
// Purpose: character receive/transmit engine with status flags and silence timer
// Assumes: mode word, divisor, limits steady while characters move
// Notes:   transmit bytes pass a 32-word FIFO ahead of the holding register
//
// How it works
// RQ1: receiver runs asynchronously while mode bit 8 is zero.
// RQ2: start accepted only after low persists more than 7 of 16x samples.
// RQ3: lows of 7/16 bit or shorter are dropped; keep hunting.
// RQ4: first data sample 24 samples after edge, then every 16.
// RQ5: clocked mode samples on each external clock rise; low is start.
// RQ6: finished character goes to holding register, avail flag after stop.
// RQ7: overrun flag set when unread character gets replaced.
// RQ8: parity checked per check type; mismatch sets check error flag.
// RQ9: stop error when stop bit low and some data bit high.
// RQ10: idle drops on start, rises after 10 stop-bit times.
// RQ11: zero silence limit disables receive time-out entirely.
// RQ12: counter loads after first char, decrements per bit (per 16 external clocks clocked), reload per byte.
// RQ13: arm command starts waiting; counting needs arm, char, nonzero limit.
// RQ14: time-out is value bit periods, or value times 16 clocks clocked.
// RQ15: transmitter sends start, data LSB first, parity, stop bits.
// RQ16: data bit count and stop count come from mode word fields.
// RQ17: even parity is data XOR; odd parity is its inverse.
// RQ18: holding byte moves to shifter when empty; hold-free flag follows.
// RQ19: all-done flag set when shifter and holding both empty.
// RQ20: nonzero gap holds line high that many bits after each byte.
// RQ21: multi-drop receive flags high parity bit; cleared by flag clear.
// RQ22: after send-address command next byte gets parity set, later cleared.
// RQ23: 16x sample tick is clock divided by divisor; zero stops it.
// RQ24: reading received character clears avail so overrun is recognised.
`timescale 1ns/1ps
module usart_char_engine
  import usart_char_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  input  wire logic               rx_line_in,
  input  wire logic               serial_ext_clock_in,
  output logic                    tx_line_out,
  input  wire logic [MODE_W-1:0]  mode_config_reg_in,
  input  wire logic [DIV_W-1:0]   divisor_in,
  input  wire logic [LIMIT_W-1:0] idle_limit_value_in,
  input  wire logic [GAP_W-1:0]   tx_gap_reg_in,
  input  wire logic               arm_silence_cmd_in,
  input  wire logic               send_addr_cmd_in,
  input  wire logic               flag_clear_in,
  input  wire logic               rx_read_in,
  output logic      [7:0]         receive_holding_reg_out,
  output logic                    rx_char_avail_out,
  output logic                    overrun_flag_out,
  output logic                    check_bit_error_flag_out,
  output logic                    stop_bit_error_flag_out,
  output logic                    rx_idle_out,
  output logic                    rx_silence_flag_out,
  input  wire logic [7:0]         tx_data_in,
  input  wire logic               tx_valid_in,
  output logic                    tx_ready_out,
  output logic                    tx_hold_free_flag_out,
  output logic                    tx_all_done_flag_out
);
  typedef struct packed {
    logic [DIV_W-1:0]   div_cnt;
    logic [3:0]         sub_cnt;
    logic               ext_prev;
    rx_state_e          rx_st;
    logic [3:0]         rx_qual;
    logic [3:0]         rx_phase;
    logic [3:0]         rx_idx;
    logic [7:0]         rx_shift;
    logic               rx_check;
    logic [7:0]         rhr;
    logic               avail;
    logic               overrun;
    logic               check_err;
    logic               stop_err;
    logic               idle;
    logic [3:0]         idle_cnt;
    logic               armed;
    logic               running;
    logic               silence;
    logic [LIMIT_W-1:0] silence_cnt;
    logic [8:0]         hold;
    logic               hold_valid;
    logic               addr_pend;
    tx_state_e          tx_st;
    logic [7:0]         tx_shift;
    logic               tx_check;
    logic [3:0]         tx_idx;
    logic [5:0]         tx_sub;
    logic [GAP_W-1:0]   gap_cnt;
    logic               tx_line;
    logic               all_done;
  } engine_s;

  engine_s st;
  engine_s next_st;

  logic [1:0] pin_level;
  logic       rx_lvl;
  logic       ext_lvl;
  logic       fifo_ready;
  logic [8:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_take;

  pin_sync3 #(.WIDTH(2)) u_pin_sync (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .pin_in        ({serial_ext_clock_in, rx_line_in}),
    .idle_level_in (2'h1),
    .level_out     (pin_level)
  );

  // rx pin reads high and external clock pin reads low until the synchroniser fills
  assign rx_lvl  = pin_level[0];
  assign ext_lvl = pin_level[1];

  word_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_in       (clk_in),
    .reset_n_in   (reset_n_in),
    .wr_data_in   ({st.addr_pend, tx_data_in}),
    .wr_valid_in  (tx_valid_in),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_take)
  );

  // holding register refills from the fifo only once it has been emptied
  assign fifo_take    = !st.hold_valid;
  assign tx_ready_out = fifo_ready;

  function automatic logic check_value(input logic [2:0] kind, input logic [7:0] data,
                                       input logic addr);
    logic v;
    v = 1'b0;
    case (kind)
      CHECK_EVEN:  v = ^data;
      CHECK_ODD:   v = ~^data;
      CHECK_SPACE: v = 1'b0;
      CHECK_MARK:  v = 1'b1;
      default:     v = addr;
    endcase
    return v;
  endfunction

  logic             clocked;
  logic [3:0]       n_bits;
  logic [2:0]       check_kind;
  logic [1:0]       stop_kind;
  logic             check_on;
  logic             multi_drop;
  logic [7:0]       data_mask;
  logic             ext_rise;
  logic             tick16;
  logic             sub_tick;
  logic             slow_tick;
  logic             bit_tick;
  logic             rx_sample;
  logic             char_done;
  logic [7:0]       rx_data;
  logic [5:0]       stop_sub;
  logic [3:0]       stop_bits_m1;
  logic             stop_done;

  // RQ16: field decode
  assign n_bits     = 4'(mode_config_reg_in[CHAR_LEN_LSB +: 2]) + BASE_DATA_BITS;
  assign check_kind = mode_config_reg_in[CHECK_TYPE_LSB +: 3];
  assign stop_kind  = mode_config_reg_in[STOP_CNT_LSB +: 2];
  // RQ1: mode select
  assign clocked    = mode_config_reg_in[CLOCKED_BIT];
  assign check_on   = (check_kind[2:1] != CHECK_NONE_HI);
  assign multi_drop = (check_kind[2:1] == CHECK_DROP_HI);
  assign data_mask  = 8'hff >> (MAX_DATA_BITS - n_bits);

  assign ext_rise  = ext_lvl && !st.ext_prev;
  // RQ23: divided sample tick
  assign tick16    = !clocked && (divisor_in != '0) && (st.div_cnt == divisor_in - 1'b1);
  assign sub_tick  = clocked ? ext_rise : tick16;
  // RQ14: timer step, one bit async or 16 external clocks when clocked
  assign slow_tick = sub_tick && (st.sub_cnt == SAMPLE_LAST);
  assign bit_tick  = clocked ? ext_rise : slow_tick;

  // RQ4: mid-bit sample point
  // RQ5: clocked sample point
  assign rx_sample = clocked ? ext_rise : (tick16 && st.rx_phase == SAMPLE_LAST);
  assign char_done = (st.rx_st == RX_STOP) && rx_sample;
  assign rx_data   = st.rx_shift >> (MAX_DATA_BITS - n_bits);

  assign stop_sub     = (stop_kind == STOP_TWO) ? STOP_SUB_TWO :
                        (stop_kind == STOP_ONE_HALF) ? STOP_SUB_HALF : STOP_SUB_ONE;
  assign stop_bits_m1 = (stop_kind == STOP_TWO) ? 4'h1 : 4'h0;
  assign stop_done    = clocked ? (bit_tick && st.tx_idx == stop_bits_m1)
                                : (sub_tick && st.tx_sub == stop_sub - 1'b1);

  always_comb begin
    next_st          = st;
    next_st.ext_prev = ext_lvl;
    if (clocked || divisor_in == '0 || tick16) begin
      next_st.div_cnt = '0;
    end else begin
      next_st.div_cnt = st.div_cnt + 1'b1;
    end
    if (sub_tick) begin
      next_st.sub_cnt = st.sub_cnt + 1'b1;
    end

    // receiver
    if (st.rx_st != RX_IDLE && tick16) begin
      next_st.rx_phase = st.rx_phase + 1'b1;
    end
    case (st.rx_st)
      RX_IDLE: begin
        if (clocked) begin
          next_st.rx_qual = '0;
          if (ext_rise && !rx_lvl) begin
            next_st.rx_st  = RX_DATA;
            next_st.rx_idx = '0;
            next_st.idle   = 1'b0;
          end
        end else if (tick16) begin
          if (rx_lvl) begin
            // RQ3: short low discarded
            next_st.rx_qual = '0;
          end else if (st.rx_qual == START_QUAL) begin
            // RQ2: eighth low sample qualifies start
            next_st.rx_st    = RX_DATA;
            next_st.rx_qual  = '0;
            next_st.rx_phase = '0;
            next_st.rx_idx   = '0;
            next_st.idle     = 1'b0;
          end else begin
            next_st.rx_qual = st.rx_qual + 1'b1;
          end
        end
      end
      RX_DATA: begin
        if (rx_sample) begin
          next_st.rx_shift = {rx_lvl, st.rx_shift[7:1]};
          next_st.rx_idx   = st.rx_idx + 1'b1;
          if (st.rx_idx == n_bits - 1'b1) begin
            next_st.rx_st = check_on ? RX_CHECK : RX_STOP;
          end
        end
      end
      RX_CHECK: begin
        if (rx_sample) begin
          next_st.rx_check = rx_lvl;
          next_st.rx_st    = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_sample) begin
          next_st.rx_st    = RX_IDLE;
          next_st.idle_cnt = '0;
        end
      end
      default: begin
        next_st.rx_st = RX_IDLE;
      end
    endcase

    // flags: software clears first so a same-cycle event still sets
    // RQ24: read clears avail
    if (rx_read_in) begin
      next_st.avail = 1'b0;
    end
    // RQ21: clear through flag clear
    if (flag_clear_in) begin
      next_st.overrun   = 1'b0;
      next_st.check_err = 1'b0;
      next_st.stop_err  = 1'b0;
      next_st.silence   = 1'b0;
    end
    if (char_done) begin
      // RQ6: transfer and avail
      next_st.rhr   = rx_data;
      next_st.avail = 1'b1;
      // RQ7: unread character replaced
      if (st.avail && !rx_read_in) begin
        next_st.overrun = 1'b1;
      end
      // RQ9: framing check
      if (!rx_lvl && (rx_data != '0)) begin
        next_st.stop_err = 1'b1;
      end
      // RQ21: address byte marks error
      if (multi_drop && st.rx_check) begin
        next_st.check_err = 1'b1;
      end
      // RQ8: parity compare
      if (check_on && !multi_drop && st.rx_check != check_value(check_kind, rx_data, 1'b0)) begin
        next_st.check_err = 1'b1;
      end
    end

    // RQ10: idle after ten stop-bit times
    if (st.rx_st == RX_IDLE && !st.idle && bit_tick) begin
      if (!rx_lvl) begin
        next_st.idle_cnt = '0;
      end else if (st.idle_cnt == IDLE_STOP_BITS - 1'b1) begin
        next_st.idle = 1'b1;
      end else begin
        next_st.idle_cnt = st.idle_cnt + 1'b1;
      end
    end

    // silence timer
    // RQ13: arm restarts the wait
    if (arm_silence_cmd_in) begin
      next_st.armed   = 1'b1;
      next_st.running = 1'b0;
    end
    if (idle_limit_value_in == '0) begin
      // RQ11: no detection
      next_st.running = 1'b0;
    end else if (char_done && (next_st.armed || st.running)) begin
      // RQ12: load or reload per byte
      next_st.running     = 1'b1;
      next_st.armed       = 1'b0;
      next_st.silence_cnt = idle_limit_value_in;
    end else if (st.running && slow_tick && !arm_silence_cmd_in) begin
      // RQ12: decrement, flag at zero
      next_st.silence_cnt = st.silence_cnt - 1'b1;
      if (st.silence_cnt == 16'h0001) begin
        next_st.silence = 1'b1;
        next_st.running = 1'b0;
      end
    end

    // transmitter
    // RQ22: pending address tag rides with the next accepted byte
    if (tx_valid_in && fifo_ready) begin
      next_st.addr_pend = 1'b0;
    end
    if (send_addr_cmd_in) begin
      next_st.addr_pend = 1'b1;
    end
    if (fifo_take && fifo_valid) begin
      next_st.hold       = fifo_data;
      next_st.hold_valid = 1'b1;
    end
    case (st.tx_st)
      TX_IDLE: begin
        next_st.tx_line = 1'b1;
        // RQ18: hold to shifter once empty
        if (st.hold_valid && bit_tick) begin
          next_st.tx_shift   = st.hold[7:0] & data_mask;
          // RQ17: parity from data sum
          // RQ22: address mark as parity bit
          next_st.tx_check   = check_value(check_kind, st.hold[7:0] & data_mask, st.hold[8]);
          next_st.hold_valid = 1'b0;
          next_st.tx_line    = 1'b0;
          next_st.tx_st      = TX_START;
        end
      end
      TX_START: begin
        // RQ15: LSB first
        if (bit_tick) begin
          next_st.tx_line  = st.tx_shift[0];
          next_st.tx_shift = st.tx_shift >> 1;
          next_st.tx_idx   = '0;
          next_st.tx_st    = TX_DATA;
        end
      end
      TX_DATA: begin
        if (bit_tick) begin
          next_st.tx_idx = st.tx_idx + 1'b1;
          if (st.tx_idx == n_bits - 1'b1) begin
            next_st.tx_idx = '0;
            next_st.tx_sub = '0;
            next_st.tx_line = check_on ? st.tx_check : 1'b1;
            next_st.tx_st   = check_on ? TX_CHECK : TX_STOP;
          end else begin
            next_st.tx_line  = st.tx_shift[0];
            next_st.tx_shift = st.tx_shift >> 1;
          end
        end
      end
      TX_CHECK: begin
        if (bit_tick) begin
          next_st.tx_line = 1'b1;
          next_st.tx_sub  = '0;
          next_st.tx_idx  = '0;
          next_st.tx_st   = TX_STOP;
        end
      end
      TX_STOP: begin
        if (sub_tick) begin
          next_st.tx_sub = st.tx_sub + 1'b1;
        end
        if (bit_tick) begin
          next_st.tx_idx = st.tx_idx + 1'b1;
        end
        // RQ16: stop length
        if (stop_done) begin
          next_st.gap_cnt = '0;
          // RQ20: optional gap
          next_st.tx_st   = (tx_gap_reg_in != '0) ? TX_GAP : TX_IDLE;
        end
      end
      TX_GAP: begin
        next_st.tx_line = 1'b1;
        if (bit_tick) begin
          if (st.gap_cnt == tx_gap_reg_in - 1'b1) begin
            next_st.tx_st = TX_IDLE;
          end else begin
            next_st.gap_cnt = st.gap_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_st.tx_st   = TX_IDLE;
        next_st.tx_line = 1'b1;
      end
    endcase
    // RQ19: everything drained
    next_st.all_done = (next_st.tx_st == TX_IDLE) && !next_st.hold_valid && !fifo_valid;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st          <= '0;
      st.idle     <= 1'b1;
      st.tx_line  <= 1'b1;
      st.all_done <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign tx_line_out              = st.tx_line;
  assign receive_holding_reg_out  = st.rhr;
  assign rx_char_avail_out        = st.avail;
  assign overrun_flag_out         = st.overrun;
  assign check_bit_error_flag_out = st.check_err;
  assign stop_bit_error_flag_out  = st.stop_err;
  assign rx_idle_out              = st.idle;
  assign rx_silence_flag_out      = st.silence;
  assign tx_hold_free_flag_out    = !st.hold_valid;
  assign tx_all_done_flag_out     = st.all_done;
endmodule // usart_char_engine

//--- hw/usart_char_pkg.sv
// Purpose: shared constants and state types of the character engine
// Assumes: one 250 MHz clock, mode settings held steady between characters
// Notes:   mode word field positions and encodings live only here
package usart_char_pkg;

  localparam int          FIFO_WIDTH      = 9;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          MODE_W          = 16;
  localparam int          DIV_W           = 16;
  localparam int          LIMIT_W         = 16;
  localparam int          GAP_W           = 8;

  // mode word layout
  localparam int          CHAR_LEN_LSB    = 6;
  localparam int          CLOCKED_BIT     = 8;
  localparam int          CHECK_TYPE_LSB  = 9;
  localparam int          STOP_CNT_LSB    = 12;

  localparam logic [2:0]  CHECK_EVEN      = 3'h0;
  localparam logic [2:0]  CHECK_ODD       = 3'h1;
  localparam logic [2:0]  CHECK_SPACE     = 3'h2;
  localparam logic [2:0]  CHECK_MARK      = 3'h3;
  localparam logic [1:0]  CHECK_NONE_HI   = 2'h2;
  localparam logic [1:0]  CHECK_DROP_HI   = 2'h3;
  localparam logic [1:0]  STOP_ONE_HALF   = 2'h1;
  localparam logic [1:0]  STOP_TWO        = 2'h2;

  localparam logic [3:0]  BASE_DATA_BITS  = 4'h5;
  localparam logic [3:0]  MAX_DATA_BITS   = 4'h8;
  localparam logic [3:0]  START_QUAL      = 4'h7;
  localparam logic [3:0]  SAMPLE_LAST     = 4'hf;
  localparam logic [3:0]  IDLE_STOP_BITS  = 4'ha;
  localparam logic [5:0]  STOP_SUB_ONE    = 6'h10;
  localparam logic [5:0]  STOP_SUB_HALF   = 6'h18;
  localparam logic [5:0]  STOP_SUB_TWO    = 6'h20;

  typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_CHECK, RX_STOP} rx_state_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_CHECK, TX_STOP, TX_GAP} tx_state_e;

endpackage

//--- hw/word_fifo.sv
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: single clock
// Notes:   full and empty come straight from the occupancy count
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } fifo_s;

  fifo_s st;
  fifo_s next_st;
  logic  push;
  logic  pop;

  assign wr_ready_out = (st.count != (AW+1)'(DEPTH));
  assign rd_valid_out = (st.count != '0);
  assign rd_data_out  = st.mem[st.rptr];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wptr] = wr_data_in;
      next_st.wptr         = st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = st.rptr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // word_fifo

//--- sim/serial_station.sv
// Purpose: remote serial station on the engine's line pins
// Assumes: bit time is a whole number of engine clocks
// Notes:   line rests high between frames
`timescale 1ns/1ps
module serial_station #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk_in,
  input  wire logic tx_line_in,
  output logic      rx_line_out
);
  initial rx_line_out = 1'b1;
  task automatic send(input logic [7:0] d, input logic par, input logic stp);
    logic [11:0] f;
    f = {1'b1, stp, par, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_in);
      #1 rx_line_out = f[i];
      repeat (BIT_CLKS - 1) @(posedge clk_in);
    end
  endtask
  task automatic glitch(input int n);
    @(posedge clk_in);
    #1 rx_line_out = 1'b0;
    repeat (n) @(posedge clk_in);
    #1 rx_line_out = 1'b1;
  endtask
  // mid-bit sampling of data and check bit
  task automatic grab(output logic [8:0] b);
    while (tx_line_in !== 1'b1) @(posedge clk_in);
    while (tx_line_in !== 1'b0) @(posedge clk_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge clk_in);
      b[i] = tx_line_in;
    end
  endtask
endmodule // serial_station

//--- sim/tb_top.sv
// Purpose: scenario bench for the character engine
// Assumes: divisor 2 and external clock period both one bit, 32 clocks; no gap
// Notes:   expected values come from the frames sent
`timescale 1ns/1ps
module tb_top;
  localparam int BIT = 32;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        rx_line, tx_line, avail, ovr, chk_err, stp_err, idle, silence;
  logic        tx_ready, hold_free, all_done;
  logic [15:0] mode = 16'h00c0;
  logic [15:0] limit = 16'h0;
  logic        arm = 1'b0, send_addr = 1'b0, flag_clear = 1'b0, rx_read = 1'b0;
  logic [7:0]  tx_data = 8'h0, rhr;
  logic        tx_valid = 1'b0, ext_clk = 1'b0;
  logic [8:0]  got;
  int          n_errors = 0, comparisons = 0, pushes = 0, first_wait = -1;
  always #2 clk_in = ~clk_in;
  always #64 ext_clk = ~ext_clk;
  usart_char_engine usart_char_engine_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .rx_line_in(rx_line),
    .serial_ext_clock_in(ext_clk), .tx_line_out(tx_line), .mode_config_reg_in(mode),
    .divisor_in(16'h0002), .idle_limit_value_in(limit), .tx_gap_reg_in(8'h00),
    .arm_silence_cmd_in(arm), .send_addr_cmd_in(send_addr), .flag_clear_in(flag_clear),
    .rx_read_in(rx_read), .receive_holding_reg_out(rhr), .rx_char_avail_out(avail),
    .overrun_flag_out(ovr), .check_bit_error_flag_out(chk_err),
    .stop_bit_error_flag_out(stp_err), .rx_idle_out(idle), .rx_silence_flag_out(silence),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .tx_hold_free_flag_out(hold_free), .tx_all_done_flag_out(all_done));
  serial_station #(.BIT_CLKS(BIT)) serial_station_i (
    .clk_in(clk_in), .tx_line_in(tx_line), .rx_line_out(rx_line));
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk_in);
    #1 s = 1'b1;
    @(posedge clk_in);
    #1 s = 1'b0;
  endtask
  task automatic bits(input int n);
    repeat (n * BIT) @(posedge clk_in);
    #1;
  endtask
  // holds until taken
  task automatic push(input logic [7:0] d);
    @(posedge clk_in);
    #1 tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) begin
      if (first_wait < 0) first_wait = pushes;
      @(posedge clk_in);
      #1;
    end
    @(posedge clk_in);
    #1 tx_valid = 1'b0;
    pushes++;
  endtask
  task automatic rx_basic();
    serial_station_i.send(8'ha5, 1'b0, 1'b1);
    chk({avail, rhr}, 9'h1a5);
    chk(9'({ovr, chk_err, stp_err}), 9'h0);
    serial_station_i.send(8'h3c, 1'b0, 1'b1);
    chk({ovr, rhr}, 9'h13c);
    pulse(rx_read);
    pulse(flag_clear);
    chk(9'({avail, ovr}), 9'h0);
  endtask
  task automatic rx_errors();
    serial_station_i.send(8'h01, 1'b0, 1'b1);
    chk(9'({chk_err, stp_err}), 9'h2);
    serial_station_i.send(8'h80, 1'b1, 1'b0);
    chk({stp_err, rhr}, 9'h180);
    bits(24);
    pulse(rx_read);
    pulse(flag_clear);
    serial_station_i.glitch(12);
    bits(2);
    chk(9'({avail, idle}), 9'h1);
  endtask
  task automatic tx_frame();
    mode = 16'h02c0;
    push(8'h5a);
    serial_station_i.grab(got);
    chk(got, 9'h15a);
    bits(3);
    chk(9'({all_done, hold_free}), 9'h3);
  endtask
  task automatic multi_drop();
    mode = 16'h0cc0;
    pulse(send_addr);
    push(8'h11);
    push(8'h22);
    serial_station_i.grab(got);
    chk(got, 9'h111);
    serial_station_i.grab(got);
    chk(got, 9'h022);
    serial_station_i.send(8'h33, 1'b1, 1'b1);
    chk(9'(chk_err), 9'h1);
    pulse(flag_clear);
    chk(9'(chk_err), 9'h0);
  endtask
  task automatic silence_wait();
    limit = 16'h0003;
    pulse(arm);
    serial_station_i.send(8'h00, 1'b0, 1'b1);
    chk(9'(silence), 9'h0);
    bits(3);
    chk(9'(silence), 9'h1);
    limit = 16'h0;
    pulse(flag_clear);
    pulse(rx_read);
  endtask
  task automatic rx_clocked();
    mode = 16'h01c0;
    @(negedge ext_clk);
    serial_station_i.send(8'h96, 1'b0, 1'b1);
    chk({avail, rhr}, 9'h196);
  endtask
  task automatic fill_fifo();
    mode = 16'h00c0;
    pushes = 0;
    for (int i = 0; i < 36; i++) push(8'(i));
    chk(9'(first_wait >= 32 && first_wait <= 35), 9'h1);
    while (all_done !== 1'b1) @(posedge clk_in);
    chk(9'(hold_free), 9'h1);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    bits(1);
    rx_basic();
    rx_errors();
    tx_frame();
    multi_drop();
    silence_wait();
    rx_clocked();
    fill_fifo();
    complete_run();
  end
  // whole run needs about 20000 clocks
  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    complete_run();
  end
endmodule // tb_top

//--- sim/usart_char_properties.sv
// Purpose: port-level checks of the character engine
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every engine instance
`timescale 1ns/1ps
module usart_char_properties
  import usart_char_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  input  wire logic               rx_line_in,
  input  wire logic               tx_line_out,
  input  wire logic               flag_clear_in,
  input  wire logic [LIMIT_W-1:0] idle_limit_value_in,
  input  wire logic               tx_valid_in,
  input  wire logic               tx_ready_out,
  input  wire logic               rx_char_avail_out,
  input  wire logic               overrun_flag_out,
  input  wire logic               check_bit_error_flag_out,
  input  wire logic               stop_bit_error_flag_out,
  input  wire logic               rx_idle_out,
  input  wire logic               rx_silence_flag_out,
  input  wire logic               tx_hold_free_flag_out,
  input  wire logic               tx_all_done_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_rx_start;
    $fell(rx_idle_out);
  endsequence
  sequence s_tx_start;
    $fell(tx_line_out);
  endsequence
  AST_START_LOW: assert property (s_rx_start |-> !$past(rx_line_in, 5))
    else $error("start without low line");
  AST_FRAME_BUSY: assert property (s_rx_start |-> !rx_idle_out [*8])
    else $error("idle inside frame");
  AST_AVAIL_IN_FRAME: assert property ($rose(rx_char_avail_out) |-> !rx_idle_out)
    else $error("ready while idle");
  AST_OVERRUN_CAUSE: assert property ($rose(overrun_flag_out) |-> $past(rx_char_avail_out))
    else $error("overrun unprovoked");
  AST_FLAG_CLEAR: assert property (flag_clear_in && rx_idle_out |=>
    !(overrun_flag_out || check_bit_error_flag_out || stop_bit_error_flag_out))
    else $error("flags survived clear");
  AST_NO_TIMEOUT: assert property (idle_limit_value_in == 16'h0 |-> !$rose(rx_silence_flag_out))
    else $error("silence with zero limit");
  AST_TX_ACCEPT: assert property (tx_valid_in && tx_ready_out |-> ##[1:2] !tx_all_done_flag_out)
    else $error("accept left done");
  AST_DONE_QUIET: assert property (tx_all_done_flag_out |-> tx_hold_free_flag_out && tx_line_out)
    else $error("done while busy");
  AST_START_BUSY: assert property (s_tx_start |-> !tx_all_done_flag_out)
    else $error("start while done");
endmodule // usart_char_properties

bind usart_char_engine usart_char_properties usart_char_properties_i (.*);
